// ===== common/flic_cfg.svh
// Purpose: Constants of the four-level interrupt controller
// Assumes: Included by bare name from design files
// Notes:   Bit positions index the joined {enable_reg_b[5:0], enable_reg_a[5:0]} word
`ifndef FLIC_CFG_SVH
`define FLIC_CFG_SVH

// Clock and machine cycle
`define FLIC_CLK_PERIOD_NS 8
`define FLIC_MC_CLOCKS     4
`define FLIC_PHASE_THREE   2
`define FLIC_CALL_MCS      4

// Source positions, register bit order
`define FLIC_BIT_EXT0      4'h0
`define FLIC_BIT_TIMER0    4'h1
`define FLIC_BIT_EXT1      4'h2
`define FLIC_BIT_TIMER1    4'h3
`define FLIC_BIT_SERIAL    4'h4
`define FLIC_BIT_BROWNOUT  4'h5
`define FLIC_BIT_TWOWIRE   4'h6
`define FLIC_BIT_KEYPAD    4'h7
`define FLIC_BIT_CMP1      4'h8
`define FLIC_BIT_CMP2      4'h9
`define FLIC_BIT_WATCHDOG  4'ha
`define FLIC_BIT_PWM       4'hb
`define FLIC_GLOBAL_EN_BIT 7

// Vector addresses
`define FLIC_VEC_EXT0      16'h0003
`define FLIC_VEC_TIMER0    16'h000b
`define FLIC_VEC_EXT1      16'h0013
`define FLIC_VEC_TIMER1    16'h001b
`define FLIC_VEC_SERIAL    16'h0023
`define FLIC_VEC_BROWNOUT  16'h002b
`define FLIC_VEC_TWOWIRE   16'h0033
`define FLIC_VEC_KEYPAD    16'h003b
`define FLIC_VEC_CMP2      16'h0043
`define FLIC_VEC_WATCHDOG  16'h0053
`define FLIC_VEC_CMP1      16'h0063
`define FLIC_VEC_PWM       16'h0073

// Sources able to leave power-down
`define FLIC_WAKE_MASK     12'h7a5

// Reset values
`define FLIC_RST_IN_SVC    4'h0
`define FLIC_RST_VECTOR    16'h0000

`endif

// ===== common/flic_pkg.sv
// Purpose: Types of the four-level interrupt controller
// Assumes: Nothing
// Notes:   Constants live in flic_cfg.svh
package flic_pkg;

   typedef enum logic [0:0] {
      FLIC_ST_IDLE = 1'b0,
      FLIC_ST_CALL = 1'b1
   } flic_state_t;

   typedef logic [1:0] flic_level_t;

endpackage

// ===== rtl/flic_core.sv
// Purpose: Four-level interrupt controller with fixed vectors
// Assumes: Core drives its instruction status as levels on this clock
// Notes:   Peripheral flags are levels from this clock domain
`timescale 1ns/1ns
`include "flic_cfg.svh"

module flic_core #(
   parameter int MC_CLOCKS = `FLIC_MC_CLOCKS,
   parameter int CALL_MCS  = `FLIC_CALL_MCS
) (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic [1:0]  ext_irq_pin_i,
   input  wire logic [1:0]  ext_trigger_sel_i,
   input  wire logic        brownout_flag_i,
   input  wire logic        watchdog_flag_i,
   input  wire logic        timer0_ovf_flag_i,
   input  wire logic        timer1_ovf_flag_i,
   input  wire logic        twowire_flag_i,
   input  wire logic        keypad_flag_i,
   input  wire logic        cmp1_flag_i,
   input  wire logic        cmp2_flag_i,
   input  wire logic        uart_tx_flag_i,
   input  wire logic        uart_rx_flag_i,
   input  wire logic        pwm_brake_flag_i,
   input  wire logic [7:0]  enable_reg_a_i,
   input  wire logic [7:0]  enable_reg_b_i,
   input  wire logic [7:0]  prio_low_bits_a_i,
   input  wire logic [7:0]  prio_high_bits_a_i,
   input  wire logic [7:0]  prio_low_bits_b_i,
   input  wire logic [7:0]  prio_high_bits_b_i,
   input  wire logic        last_cycle_i,
   input  wire logic        reg_write_instr_i,
   input  wire logic        isr_exit_i,
   input  wire logic        idle_i,
   input  wire logic        power_down_i,
   output logic             hw_long_call_o,
   output logic             push_pc_o,
   output logic             load_pc_o,
   output logic [15:0]      vector_o,
   output logic [11:0]      irq_ack_o,
   output logic [3:0]       in_service_o,
   output logic [1:0]       ext_request_flag_o,
   output logic             wake_o
);

   localparam int CALL_CLKS = MC_CLOCKS * CALL_MCS;
   localparam int PW        = $clog2(MC_CLOCKS);
   localparam int CW        = $clog2(CALL_CLKS);
   localparam logic [PW-1:0] PHASE_LAST = PW'(MC_CLOCKS - 1);
   localparam logic [PW-1:0] PHASE_THREE = PW'(`FLIC_PHASE_THREE);
   localparam logic [CW-1:0] CALL_END   = CW'(CALL_CLKS - 1);
   localparam logic [CW-1:0] LOAD_AT    = CW'(CALL_CLKS - 2);

   if (MC_CLOCKS < 3 || CALL_MCS < 1) begin : g_check
      $error("flic_core: machine cycle needs phase three and a call length");
   end

   // Fixed arbitration rank to register bit position
   function automatic logic [3:0] rank_pos(input logic [3:0] rank);
      case (rank)
         4'h0:    rank_pos = `FLIC_BIT_EXT0;
         4'h1:    rank_pos = `FLIC_BIT_BROWNOUT;
         4'h2:    rank_pos = `FLIC_BIT_WATCHDOG;
         4'h3:    rank_pos = `FLIC_BIT_TIMER0;
         4'h4:    rank_pos = `FLIC_BIT_TWOWIRE;
         4'h5:    rank_pos = `FLIC_BIT_EXT1;
         4'h6:    rank_pos = `FLIC_BIT_KEYPAD;
         4'h7:    rank_pos = `FLIC_BIT_CMP1;
         4'h8:    rank_pos = `FLIC_BIT_TIMER1;
         4'h9:    rank_pos = `FLIC_BIT_CMP2;
         4'ha:    rank_pos = `FLIC_BIT_SERIAL;
         default: rank_pos = `FLIC_BIT_PWM;
      endcase
   endfunction

   function automatic logic [15:0] vec_of(input logic [3:0] pos);
      case (pos)
         `FLIC_BIT_EXT0:     vec_of = `FLIC_VEC_EXT0;
         `FLIC_BIT_TIMER0:   vec_of = `FLIC_VEC_TIMER0;
         `FLIC_BIT_EXT1:     vec_of = `FLIC_VEC_EXT1;
         `FLIC_BIT_TIMER1:   vec_of = `FLIC_VEC_TIMER1;
         `FLIC_BIT_SERIAL:   vec_of = `FLIC_VEC_SERIAL;
         `FLIC_BIT_BROWNOUT: vec_of = `FLIC_VEC_BROWNOUT;
         `FLIC_BIT_TWOWIRE:  vec_of = `FLIC_VEC_TWOWIRE;
         `FLIC_BIT_KEYPAD:   vec_of = `FLIC_VEC_KEYPAD;
         `FLIC_BIT_CMP1:     vec_of = `FLIC_VEC_CMP1;
         `FLIC_BIT_CMP2:     vec_of = `FLIC_VEC_CMP2;
         `FLIC_BIT_WATCHDOG: vec_of = `FLIC_VEC_WATCHDOG;
         default:            vec_of = `FLIC_VEC_PWM;
      endcase
   endfunction

   // Winner: higher level first, then better rank; {found, position}
   function automatic logic [4:0] pick(input logic [11:0] req, input logic [11:0] hi,
                                       input logic [11:0] lo);
      logic [3:0] pos;
      logic [3:0] win;
      logic [1:0] best;
      logic       found;
      win   = 4'h0;
      best  = 2'h0;
      found = 1'b0;
      for (int r = 11; r >= 0; r--) begin
         pos = rank_pos(4'(r));
         if (req[pos] && (!found || {hi[pos], lo[pos]} >= best)) begin
            found = 1'b1;
            best  = {hi[pos], lo[pos]};
            win   = pos;
         end
      end
      pick = {found, win};
   endfunction

   function automatic logic [3:0] top_bit(input logic [3:0] svc);
      top_bit = svc[3] ? 4'h8 : svc[2] ? 4'h4 : svc[1] ? 4'h2 : svc[0] ? 4'h1 : 4'h0;
   endfunction

   flic_pkg::flic_state_t state;
   flic_pkg::flic_state_t next_state;
   logic [PW-1:0]         phase;
   logic [CW-1:0]         call_cnt;
   logic [11:0]           flags;
   logic [11:0]           en12;
   logic [11:0]           hi12;
   logic [11:0]           lo12;
   logic [11:0]           elig;
   logic [4:0]            sel;
   logic [3:0]            sel_pos;
   flic_pkg::flic_level_t sel_lvl;
   flic_pkg::flic_level_t top_lvl;
   logic [3:0]            top_one;
   logic [3:0]            sel_one;
   logic                  clock_phase_three;
   logic                  poll;
   logic                  preempt_ok;
   logic                  take;
   logic                  pop;
   logic [11:0]           next_ack;
   logic [3:0]            next_in_svc;
   logic                  next_wake;

   assign clock_phase_three = (phase == PHASE_THREE);

   for (genvar g = 0; g < 2; g++) begin : g_ext
      flic_ext_sampler u_sampler (
         .clk_i       (clk_i),
         .rstn_i      (rstn_i),
         .pin_i       (ext_irq_pin_i[g]),
         .edge_mode_i (ext_trigger_sel_i[g]),
         .sample_i    (clock_phase_three),
         .ack_i       (next_ack[g * 2]),
         .flag_o      (ext_request_flag_o[g])
      );
   end

   // Flags in register bit order; read before this edge's update
   assign flags[`FLIC_BIT_EXT0]     = ext_request_flag_o[0];
   assign flags[`FLIC_BIT_TIMER0]   = timer0_ovf_flag_i;
   assign flags[`FLIC_BIT_EXT1]     = ext_request_flag_o[1];
   assign flags[`FLIC_BIT_TIMER1]   = timer1_ovf_flag_i;
   assign flags[`FLIC_BIT_SERIAL]   = uart_tx_flag_i | uart_rx_flag_i;
   assign flags[`FLIC_BIT_BROWNOUT] = brownout_flag_i;
   assign flags[`FLIC_BIT_TWOWIRE]  = twowire_flag_i;
   assign flags[`FLIC_BIT_KEYPAD]   = keypad_flag_i;
   assign flags[`FLIC_BIT_CMP1]     = cmp1_flag_i;
   assign flags[`FLIC_BIT_CMP2]     = cmp2_flag_i;
   assign flags[`FLIC_BIT_WATCHDOG] = watchdog_flag_i;
   assign flags[`FLIC_BIT_PWM]      = pwm_brake_flag_i;

   assign en12 = {enable_reg_b_i[5:0], enable_reg_a_i[5:0]};
   assign hi12 = {prio_high_bits_b_i[5:0], prio_high_bits_a_i[5:0]};
   assign lo12 = {prio_low_bits_b_i[5:0], prio_low_bits_a_i[5:0]};
   assign elig = flags & en12 & {12{enable_reg_a_i[`FLIC_GLOBAL_EN_BIT]}};

   assign sel     = pick(elig, hi12, lo12);
   assign sel_pos = sel[3:0];
   assign sel_lvl = {hi12[sel_pos], lo12[sel_pos]};
   assign sel_one = 4'h1 << sel_lvl;
   assign top_one = top_bit(in_service_o);
   assign top_lvl = top_one[3] ? 2'h3 : top_one[2] ? 2'h2 : top_one[1] ? 2'h1 : 2'h0;

   // Level 3 has nothing above it, so it is never preempted
   assign preempt_ok = (in_service_o == 4'h0) || (sel_lvl > top_lvl);
   assign poll       = (state == flic_pkg::FLIC_ST_IDLE) && clock_phase_three;
   // Poll outside the last cycle simply waits for a later one
   assign take = poll && sel[4] && preempt_ok && last_cycle_i
                 && !reg_write_instr_i && !isr_exit_i;
   // Only the interrupt return ends a service level, not a plain return
   assign pop  = poll && last_cycle_i && isr_exit_i;

   assign next_ack    = take ? (12'h001 << sel_pos) : 12'h000;
   assign next_in_svc = take ? (in_service_o | sel_one) :
                        pop  ? (in_service_o & ~top_one) : in_service_o;
   assign next_wake   = (power_down_i && |(elig & `FLIC_WAKE_MASK))
                        || (idle_i && |elig);

   always_comb begin
      case (state)
         flic_pkg::FLIC_ST_IDLE: next_state = take ? flic_pkg::FLIC_ST_CALL : flic_pkg::FLIC_ST_IDLE;
         flic_pkg::FLIC_ST_CALL: next_state = (call_cnt == CALL_END) ? flic_pkg::FLIC_ST_IDLE
                                                                      : flic_pkg::FLIC_ST_CALL;
         default:                next_state = flic_pkg::FLIC_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase    <= '0;
         state    <= flic_pkg::FLIC_ST_IDLE;
         call_cnt <= '0;
      end else begin
         phase    <= (phase == PHASE_LAST) ? '0 : phase + PW'(1);
         state    <= next_state;
         call_cnt <= (state == flic_pkg::FLIC_ST_CALL) ? call_cnt + CW'(1) : '0;
      end
   end

   // Stack push of the PC only; the status word is the routine's job
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hw_long_call_o <= 1'b0;
         push_pc_o      <= 1'b0;
         load_pc_o      <= 1'b0;
         vector_o       <= `FLIC_RST_VECTOR;
         irq_ack_o      <= 12'h000;
         in_service_o   <= `FLIC_RST_IN_SVC;
         wake_o         <= 1'b0;
      end else begin
         hw_long_call_o <= (next_state == flic_pkg::FLIC_ST_CALL);
         push_pc_o      <= take;
         load_pc_o      <= (state == flic_pkg::FLIC_ST_CALL) && (call_cnt == LOAD_AT);
         vector_o       <= take ? vec_of(sel_pos) : vector_o;
         irq_ack_o      <= next_ack;
         in_service_o   <= next_in_svc;
         wake_o         <= next_wake;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   AST_CALL_LENGTH: assert property (
      push_pc_o |-> hw_long_call_o ##15 (load_pc_o && hw_long_call_o) ##1 !hw_long_call_o)
      else $error("Vector call not four machine cycles long");
   AST_STRICT_PREEMPT: assert property (
      push_pc_o |-> ($past(in_service_o) == 4'h0) || ($past(sel_lvl) > $past(top_lvl)))
      else $error("Call taken without a strictly higher level");
   AST_LEVEL3_HELD: assert property (
      push_pc_o |-> !$past(in_service_o[3]))
      else $error("Level 3 routine was preempted");
   AST_GLOBAL_BLOCK: assert property (
      push_pc_o |-> $past(enable_reg_a_i[`FLIC_GLOBAL_EN_BIT]) && $past(en12[sel_pos]))
      else $error("Call taken while disabled");
   AST_CALL_WINDOW: assert property (
      push_pc_o |-> $past(last_cycle_i) && !$past(reg_write_instr_i) && !$past(isr_exit_i))
      else $error("Call outside the allowed instruction window");
   AST_ACK_ONE: assert property (
      push_pc_o ? $onehot(irq_ack_o) : (irq_ack_o == 12'h000))
      else $error("Acknowledge not one strobe at vectoring");
   AST_EXIT_POP: assert property (
      (pop && in_service_o[3]) |=> !in_service_o[3] && (in_service_o[2:0] == $past(in_service_o[2:0])))
      else $error("Interrupt return did not clear the top level");
   AST_POLL_PHASE: assert property (
      push_pc_o |-> $past(phase) == PHASE_THREE)
      else $error("Call decided away from phase three");
   AST_VECTOR_FORM: assert property (
      push_pc_o |-> (vector_o[2:0] == 3'h3) && (vector_o[15:7] == 9'h000))
      else $error("Vector outside the table");
   AST_WAKE_MASK: assert property (
      (power_down_i && !idle_i && !(|(elig & `FLIC_WAKE_MASK))) |=> !wake_o)
      else $error("Non-waking source left power-down");

   COV_CALL:    cover property (push_pc_o ##16 !hw_long_call_o);
   COV_NESTED:  cover property (push_pc_o && $past(in_service_o) != 4'h0);
   COV_WAKE:    cover property (power_down_i && wake_o);
   COV_RETURN:  cover property (pop && in_service_o != 4'h0);

endmodule // flic_core

// ===== rtl/flic_ext_sampler.sv
// Purpose: External interrupt pin sampler and request flag
// Assumes: sample_i is one clock per machine cycle, at phase three
// Notes:   Pin is asynchronous and passes two flip-flops first
`timescale 1ns/1ns
module flic_ext_sampler (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic pin_i,
   input  wire logic edge_mode_i,
   input  wire logic sample_i,
   input  wire logic ack_i,
   output logic      flag_o
);

   logic sync_a;
   logic sync_b;
   logic prev;
   logic fall;
   logic next_flag;

   assign fall      = prev & ~sync_b;
   // Edge mode: set wins over the vectoring clear
   assign next_flag = edge_mode_i ? (fall | (flag_o & ~ack_i)) : ~sync_b;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
         prev   <= 1'b1;
         flag_o <= 1'b0;
      end else begin
         sync_a <= pin_i;
         sync_b <= sync_a;
         if (sample_i) begin
            prev   <= sync_b;
            flag_o <= next_flag;
         end
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   AST_EDGE_SET: assert property (
      (sample_i && edge_mode_i && prev && !sync_b) |=> flag_o)
      else $error("Falling edge did not set the request flag");
   AST_LEVEL_FOLLOW: assert property (
      (sample_i && !edge_mode_i) |=> (flag_o == !$past(sync_b)))
      else $error("Level flag does not follow the pin");
   AST_EDGE_ACK_CLEAR: assert property (
      (sample_i && edge_mode_i && ack_i && !(prev && !sync_b)) |=> !flag_o)
      else $error("Edge flag not cleared on vectoring");
   AST_HOLD_BETWEEN: assert property (
      !sample_i |=> $stable(flag_o))
      else $error("Flag changed outside phase three");

endmodule // flic_ext_sampler

// ===== tb/flic_src_model.sv
// Purpose: Peripheral flag sources facing the interrupt controller
// Assumes: Bench raises and lowers req_i between rising edges
// Notes:   Slots follow the acknowledge order; slot 0 carries the transmit flag
`timescale 1ns/1ns
module flic_src_model (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic [11:0] req_i,
   input  wire logic [11:0] ack_i,
   output logic      [11:0] flag_o
);
   localparam logic [11:0] TIMER_SLOTS = 12'h00a;
   logic [11:0] req_q;
   logic [11:0] next_flag;
   // New event sets, software lowers, timer flags drop on acknowledge
   assign next_flag = req_i & (flag_o | ~req_q) & ~(ack_i & TIMER_SLOTS);
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         req_q  <= 12'h000;
         flag_o <= 12'h000;
      end else begin
         req_q  <= req_i;
         flag_o <= next_flag;
      end
   end
endmodule // flic_src_model

// ===== tb/tb_four_level_interrupt_controller.sv
// Purpose: Self-checking bench of the four-level interrupt controller
// Assumes: Default machine cycle of four clocks and call of four machine cycles
// Notes:   Stimulus changes at falling edges, outputs are sampled there too
`timescale 1ns/1ns
module tb_four_level_interrupt_controller;
   localparam logic [15:0] VEC [12] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
                                        16'h0033, 16'h003b, 16'h0063, 16'h0043, 16'h0053, 16'h0073};
   localparam int          RANK [12] = '{0, 5, 10, 1, 6, 2, 7, 8, 3, 9, 4, 11};
   localparam logic [11:0] WAKE = 12'h7a5;
   logic        clk_i;
   logic        rstn_i;
   logic [1:0]  pin;
   logic [1:0]  trig;
   logic [11:0] en;
   logic [11:0] lo;
   logic [11:0] hi;
   logic [11:0] req;
   logic [11:0] flg;
   logic        ga;
   logic        last_cycle_i;
   logic        reg_write_instr_i;
   logic        isr_exit_i;
   logic        idle_i;
   logic        power_down_i;
   logic        hw_long_call_o;
   logic        push_pc_o;
   logic        load_pc_o;
   logic [15:0] vector_o;
   logic [11:0] irq_ack_o;
   logic [3:0]  in_service_o;
   logic [1:0]  ext_request_flag_o;
   logic        wake_o;
   int          bad_count;
   int          n_compared;
   int          cycles = 0;

   flic_core flic_core_i (
      .clk_i              (clk_i),
      .rstn_i             (rstn_i),
      .ext_irq_pin_i      (pin),
      .ext_trigger_sel_i  (trig),
      .brownout_flag_i    (flg[5]),
      .watchdog_flag_i    (flg[10]),
      .timer0_ovf_flag_i  (flg[1]),
      .timer1_ovf_flag_i  (flg[3]),
      .twowire_flag_i     (flg[6]),
      .keypad_flag_i      (flg[7]),
      .cmp1_flag_i        (flg[8]),
      .cmp2_flag_i        (flg[9]),
      .uart_tx_flag_i     (flg[0]),
      .uart_rx_flag_i     (flg[4]),
      .pwm_brake_flag_i   (flg[11]),
      .enable_reg_a_i     ({ga, 1'b0, en[5:0]}),
      .enable_reg_b_i     ({2'b00, en[11:6]}),
      .prio_low_bits_a_i  ({2'b00, lo[5:0]}),
      .prio_high_bits_a_i ({2'b00, hi[5:0]}),
      .prio_low_bits_b_i  ({2'b00, lo[11:6]}),
      .prio_high_bits_b_i ({2'b00, hi[11:6]}),
      .last_cycle_i       (last_cycle_i),
      .reg_write_instr_i  (reg_write_instr_i),
      .isr_exit_i         (isr_exit_i),
      .idle_i             (idle_i),
      .power_down_i       (power_down_i),
      .hw_long_call_o     (hw_long_call_o),
      .push_pc_o          (push_pc_o),
      .load_pc_o          (load_pc_o),
      .vector_o           (vector_o),
      .irq_ack_o          (irq_ack_o),
      .in_service_o       (in_service_o),
      .ext_request_flag_o (ext_request_flag_o),
      .wake_o             (wake_o)
   );

   flic_src_model flic_src_model_i (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .req_i  (req),
      .ack_i  (irq_ack_o),
      .flag_o (flg)
   );

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         results();
      end
   end

   task automatic results();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Pins are low-active requests, slot 4 raises both serial flags
   task automatic drive(input int i, input logic v);
      if (i == 0)
         pin[0] = ~v;
      else if (i == 2)
         pin[1] = ~v;
      else
         req[i] = v;
      if (i == 4)
         req[0] = v;
   endtask

   task automatic expect_call(input int i, input logic [3:0] svc);
      int n;
      n = 0;
      while (push_pc_o !== 1'b1 && n < 48) begin
         @(negedge clk_i);
         n++;
      end
      chk("push_pc", push_pc_o, 1);
      chk("call_busy", hw_long_call_o, 1);
      chk("vector", vector_o, VEC[i]);
      chk("ack", irq_ack_o, 16'h1 << i);
      chk("in_service", in_service_o, svc);
      repeat (15) @(negedge clk_i);
      chk("load_pc", load_pc_o, 1);
      @(negedge clk_i);
      chk("call_busy", hw_long_call_o, 0);
   endtask

   task automatic no_call(input int n);
      repeat (n) begin
         @(negedge clk_i);
         chk("no_push", push_pc_o, 0);
      end
   endtask

   task automatic exit_isr(input logic [3:0] svc);
      isr_exit_i = 1'b1;
      repeat (4) @(negedge clk_i);
      isr_exit_i = 1'b0;
      chk("in_service", in_service_o, svc);
   endtask

   task automatic s_vectors();
      for (int i = 0; i < 12; i++) begin
         en = 12'h1 << i;
         drive(i, 1'b1);
         expect_call(i, 4'h1);
         if (i == 0)
            chk("ext0_flag", ext_request_flag_o[0], 0);
         if (i == 2)
            chk("ext1_flag", ext_request_flag_o[1], 1);
         drive(i, 1'b0);
         repeat (8) @(negedge clk_i);
         exit_isr(4'h0);
      end
   endtask

   task automatic s_level();
      en = 12'h004;
      drive(2, 1'b1);
      expect_call(2, 4'h1);
      exit_isr(4'h0);
      expect_call(2, 4'h1);
      drive(2, 1'b0);
      repeat (8) @(negedge clk_i);
      exit_isr(4'h0);
   endtask

   // All sources at level 1 at once, served one by one
   task automatic s_rank();
      en = 12'hfff;
      lo = 12'hfff;
      last_cycle_i = 1'b0;
      for (int i = 0; i < 12; i++)
         drive(i, 1'b1);
      repeat (16) @(negedge clk_i);
      last_cycle_i = 1'b1;
      for (int k = 0; k < 12; k++) begin
         expect_call(RANK[k], 4'h2);
         drive(RANK[k], 1'b0);
         repeat (8) @(negedge clk_i);
         exit_isr(4'h0);
      end
   endtask

   // Levels: ext0 0, timer0 2, watchdog 3, brake 3
   task automatic s_prio();
      en = 12'hc03;
      lo = 12'hc00;
      hi = 12'hc02;
      drive(0, 1'b1);
      drive(1, 1'b1);
      drive(11, 1'b1);
      expect_call(11, 4'h8);
      no_call(32);
      drive(11, 1'b0);
      exit_isr(4'h0);
      expect_call(1, 4'h4);
      no_call(32);
      drive(10, 1'b1);
      expect_call(10, 4'hc);
      drive(10, 1'b0);
      exit_isr(4'h4);
      // One clock with the exit strobe low between two returns
      @(negedge clk_i);
      exit_isr(4'h0);
      expect_call(0, 4'h1);
      drive(0, 1'b0);
      drive(1, 1'b0);
      exit_isr(4'h0);
   endtask

   task automatic s_gates();
      en = 12'h100;
      lo = 12'h000;
      hi = 12'h000;
      ga = 1'b0;
      drive(8, 1'b1);
      no_call(24);
      drive(8, 1'b0);
      @(negedge clk_i);
      ga = 1'b1;
      no_call(24);
      last_cycle_i = 1'b0;
      drive(8, 1'b1);
      no_call(24);
      last_cycle_i = 1'b1;
      reg_write_instr_i = 1'b1;
      no_call(24);
      reg_write_instr_i = 1'b0;
      expect_call(8, 4'h1);
      drive(8, 1'b0);
      exit_isr(4'h0);
   endtask

   // Calls held off so that flags stay up while wake is judged
   task automatic s_wake();
      trig = 2'b00;
      last_cycle_i = 1'b0;
      power_down_i = 1'b1;
      for (int i = 0; i < 12; i++) begin
         en = 12'h1 << i;
         drive(i, 1'b1);
         repeat (10) @(negedge clk_i);
         chk("wake", wake_o, WAKE[i]);
         drive(i, 1'b0);
         repeat (10) @(negedge clk_i);
      end
      power_down_i = 1'b0;
      idle_i = 1'b1;
      en = 12'h004;
      drive(2, 1'b1);
      repeat (10) @(negedge clk_i);
      chk("wake_idle", wake_o, 1);
      drive(2, 1'b0);
   endtask

   initial begin
      bad_count = 0;
      n_compared = 0;
      pin = 2'b11;
      trig = 2'b01;
      en = 12'h000;
      lo = 12'h000;
      hi = 12'h000;
      req = 12'h000;
      ga = 1'b1;
      last_cycle_i = 1'b1;
      reg_write_instr_i = 1'b0;
      isr_exit_i = 1'b0;
      idle_i = 1'b0;
      power_down_i = 1'b0;
      rstn_i = 1'b0;
      repeat (4) @(negedge clk_i);
      rstn_i = 1'b1;
      s_vectors();
      s_level();
      s_rank();
      s_prio();
      s_gates();
      s_wake();
      results();
   end
endmodule // tb_four_level_interrupt_controller
